// [rlt_pkg.sv]
// Constants for the reload timer with oscillator capture: register offsets,
// control bit positions, reset values and clock divider counts.
// Assumes a 40 MHz system clock and an APB master with 32-bit data.
//
// Functional notes
// RULE1: Sixteen-bit count from two bytes, split selectable.
// RULE2: Clock from sysclk, sysclk/12, or synchronised external/8.
// RULE3: Sixteen-bit wrap loads reload pair, sets high flag; while capture enable is set the code loads zero instead.
// RULE4: Sixteen-bit mode interrupts on every overflow.
// RULE5: Low-byte wrap interrupts when low enable set.
// RULE6: Split mode: each byte reloads from own reload.
// RULE7: Split mode: run gates high byte only.
// RULE8: Split byte clock from own select and external select.
// RULE9: Split mode: each byte wrap sets its flag.
// RULE10: Split interrupts on high, or either with enable.
// RULE11: Overflow flags cleared only by software.
// RULE12: Handler reads both flags to find source.
// RULE13: Capture mode counts sysclk or sysclk/12.
// RULE14: Capture copies count to reloads, sets high flag.
// RULE15: Capture on each falling edge of external/8.
// RULE16: Software keeps sixteen-bit mode while capturing.
// RULE17: Software picks fast count clock, differences captures.
// RULE18: Capture active only while capture enable set.
// RULE19: Low flag set on every low wrap, any mode.
// RULE20: Run gates whole sixteen-bit counter; bytes reset zero.
`default_nettype none

package rlt_pkg;

    // Register byte addresses
    localparam logic [7:0] OFF_CTRL   = 8'h00;
    localparam logic [7:0] OFF_CLKCTL = 8'h04;
    localparam logic [7:0] OFF_RLDLO  = 8'h08;
    localparam logic [7:0] OFF_RLDHI  = 8'h0C;
    localparam logic [7:0] OFF_CNTLO  = 8'h10;
    localparam logic [7:0] OFF_CNTHI  = 8'h14;

    // timer_control_register bit positions
    localparam int BIT_HIGH_FLAG = 7;
    localparam int BIT_LOW_FLAG  = 6;
    localparam int BIT_LOW_IRQEN = 5;
    localparam int BIT_CAPT_EN   = 4;
    localparam int BIT_SPLIT     = 3;
    localparam int BIT_RUN       = 2;
    localparam int BIT_EXT_CLK   = 0;

    // clock_control_register bit positions
    localparam int BIT_LOW_CLKSEL  = 0;
    localparam int BIT_HIGH_CLKSEL = 1;
    localparam int BIT_TIMER_IRQEN = 2;

    // Reset values
    localparam logic [7:0] RST_BYTE = 8'h00;

    // Divider counts
    localparam logic [3:0] DIV12_LAST = 4'hB;
    localparam logic [2:0] EXT8_LAST  = 3'h7;

    // Wrap values
    localparam logic [7:0]  BYTE_MAX = 8'hFF;
    localparam logic [15:0] WORD_MAX = 16'hFFFF;

endpackage

`default_nettype wire

// [rlt_ext_div.sv]
// External oscillator synchroniser and divide-by-8.
// Assumes extOsc is asynchronous to clk and well below clk/2.
`default_nettype none

module rlt_ext_div (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic extOsc,
    output logic      extTick
);
    import rlt_pkg::*;

    logic       sync1_q;
    logic       sync2_q;
    logic       sync3_q;
    logic [2:0] divCnt_q;

    ////////////////////////////////////////////////////////////////////////
    // Two-flop synchroniser plus a delayed copy for edge detection
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            sync1_q <= 1'b0;
            sync2_q <= 1'b0;
            sync3_q <= 1'b0;
        end else begin
            sync1_q <= extOsc;
            sync2_q <= sync1_q;
            sync3_q <= sync2_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // RULE15 falling edge of /8
    // Divided level is divCnt_q[2]; it falls when the count wraps 7 to 0
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            divCnt_q <= 3'h0;
        end else if (sync2_q && !sync3_q) begin
            divCnt_q <= divCnt_q + 3'h1;
        end
    end

    assign extTick = sync2_q && !sync3_q && (divCnt_q == EXT8_LAST);

endmodule

`default_nettype wire

// [rlt_timer.sv]
// Reload timer with oscillator capture, APB register slave.
// Assumes an APB master on clk; extOsc is an asynchronous pin.
//
// Design decisions made here: the address map and the APB register port.
`default_nettype none

module rlt_timer (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        extOsc,
    output logic             timerIrq
);
    import rlt_pkg::*;

    logic [7:0] ctrl_q;
    logic [2:0] clkCtl_q;
    logic [7:0] rldLo_q;
    logic [7:0] rldHi_q;
    logic [7:0] cntLo_q;
    logic [7:0] cntHi_q;
    logic [7:0] cntLo_d;
    logic [7:0] cntHi_d;
    logic [3:0] div12Cnt_q;
    logic [31:0] rdata_q;
    logic       div12Tick;
    logic       extTick;
    logic       split;
    logic       run;
    logic       captEn;
    logic       extSel;
    logic       lowTick;
    logic       highTick;
    logic       wordTick;
    logic       wordWrap;
    logic       lowWrap;
    logic       highWrap;
    logic       capture;
    logic       access;
    logic       wrCtrl;
    logic       wrClk;
    logic       wrRldLo;
    logic       wrRldHi;
    logic       wrCntLo;
    logic       wrCntHi;
    logic       mapped;
    logic [7:0] rdByte;

    assign split  = ctrl_q[BIT_SPLIT];
    assign run    = ctrl_q[BIT_RUN];
    assign captEn = ctrl_q[BIT_CAPT_EN];
    assign extSel = ctrl_q[BIT_EXT_CLK];

    ////////////////////////////////////////////////////////////////////////
    // RULE2 sysclk/12 prescaler
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            div12Cnt_q <= 4'h0;
        end else if (div12Cnt_q == DIV12_LAST) begin
            div12Cnt_q <= 4'h0;
        end else begin
            div12Cnt_q <= div12Cnt_q + 4'h1;
        end
    end

    assign div12Tick = (div12Cnt_q == DIV12_LAST);

    // RULE2 synchronised external /8
    rlt_ext_div u_extDiv (
        .clk     (clk),
        .rst_n   (rst_n),
        .extOsc  (extOsc),
        .extTick (extTick)
    );

    ////////////////////////////////////////////////////////////////////////
    // RULE8 per-byte clock choice
    // Select bit set means every sysclk edge counts
    assign lowTick  = clkCtl_q[BIT_LOW_CLKSEL]  ? 1'b1 : (extSel ? extTick : div12Tick);
    assign highTick = clkCtl_q[BIT_HIGH_CLKSEL] ? 1'b1 : (extSel ? extTick : div12Tick);

    // RULE13 capture clock
    // External clock is the thing measured, so it cannot also count
    assign wordTick = captEn ? (clkCtl_q[BIT_LOW_CLKSEL] ? 1'b1 : div12Tick) : lowTick;

    // RULE20 run gates word counter
    assign wordWrap = !split && run && wordTick && ({cntHi_q, cntLo_q} == WORD_MAX);

    // RULE19 low wrap in either mode
    assign lowWrap  = (split ? lowTick : (run && wordTick)) && (cntLo_q == BYTE_MAX);
    assign highWrap = split ? (run && highTick && cntHi_q == BYTE_MAX) : wordWrap;

    // RULE15 RULE18 capture event
    assign capture  = captEn && extTick;

    ////////////////////////////////////////////////////////////////////////
    // APB decode: zero wait states, write at the access edge
    assign access  = psel && penable;
    assign wrCtrl  = access && pwrite && paddr == OFF_CTRL;
    assign wrClk   = access && pwrite && paddr == OFF_CLKCTL;
    assign wrRldLo = access && pwrite && paddr == OFF_RLDLO;
    assign wrRldHi = access && pwrite && paddr == OFF_RLDHI;
    assign wrCntLo = access && pwrite && paddr == OFF_CNTLO;
    assign wrCntHi = access && pwrite && paddr == OFF_CNTHI;
    assign mapped  = paddr == OFF_CTRL || paddr == OFF_CLKCTL || paddr == OFF_RLDLO
                  || paddr == OFF_RLDHI || paddr == OFF_CNTLO || paddr == OFF_CNTHI;
    assign pready  = 1'b1;
    assign pslverr = access && !mapped;
    assign prdata  = rdata_q;

    // Read mux; bit 1 of the control register always reads zero
    always_comb begin
        case (paddr)
            OFF_CTRL:   rdByte = ctrl_q & 8'hFD;
            OFF_CLKCTL: rdByte = {5'h00, clkCtl_q};
            OFF_RLDLO:  rdByte = rldLo_q;
            OFF_RLDHI:  rdByte = rldHi_q;
            OFF_CNTLO:  rdByte = cntLo_q;
            OFF_CNTHI:  rdByte = cntHi_q;
            default:    rdByte = 8'h00;
        endcase
    end

    // Read data sampled in the setup cycle, so it is a flop in the access cycle
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rdata_q <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            rdata_q <= {24'h00_0000, rdByte};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Control register; flags are set by hardware, cleared by software
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ctrl_q <= RST_BYTE;
        end else begin
            if (wrCtrl) begin
                ctrl_q <= pwdata[7:0] & 8'hFD;
            end
            // RULE11 set beats clear
            if (highWrap || capture) begin
                ctrl_q[BIT_HIGH_FLAG] <= 1'b1;
            end
            // RULE9 low flag set
            if (lowWrap) begin
                ctrl_q[BIT_LOW_FLAG] <= 1'b1;
            end
        end
    end

    // Clock selects and timer interrupt enable
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            clkCtl_q <= 3'h0;
        end else if (wrClk) begin
            clkCtl_q <= pwdata[2:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // RULE14 capture into reloads
    // Capture wins over a software write in the same cycle
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rldLo_q <= RST_BYTE;
            rldHi_q <= RST_BYTE;
        end else if (capture) begin
            rldLo_q <= cntLo_q;
            rldHi_q <= cntHi_q;
        end else begin
            if (wrRldLo) begin
                rldLo_q <= pwdata[7:0];
            end
            if (wrRldHi) begin
                rldHi_q <= pwdata[7:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // RULE1 count next value
    always_comb begin
        cntLo_d = cntLo_q;
        cntHi_d = cntHi_q;
        if (split) begin
            // RULE6 RULE7 independent bytes
            if (lowTick) begin
                cntLo_d = lowWrap ? rldLo_q : cntLo_q + 8'h01;
            end
            if (run && highTick) begin
                cntHi_d = highWrap ? rldHi_q : cntHi_q + 8'h01;
            end
        end else if (run && wordTick) begin
            // RULE3 RULE18 word reload, none while capturing
            if (wordWrap) begin
                cntLo_d = captEn ? 8'h00 : rldLo_q;
                cntHi_d = captEn ? 8'h00 : rldHi_q;
            end else begin
                {cntHi_d, cntLo_d} = {cntHi_q, cntLo_q} + 16'h0001;
            end
        end
        if (wrCntLo) begin
            cntLo_d = pwdata[7:0];
        end
        if (wrCntHi) begin
            cntHi_d = pwdata[7:0];
        end
    end

    // RULE20 count bytes reset zero
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cntLo_q <= RST_BYTE;
            cntHi_q <= RST_BYTE;
        end else begin
            cntLo_q <= cntLo_d;
            cntHi_q <= cntHi_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // RULE4 RULE5 RULE10 interrupt level
    // Level follows the flags and enables, so it drops only when software clears a flag or an enable
    assign timerIrq = clkCtl_q[BIT_TIMER_IRQEN] && (ctrl_q[BIT_HIGH_FLAG]
                   || (ctrl_q[BIT_LOW_IRQEN] && ctrl_q[BIT_LOW_FLAG]));

    ////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence noCntWrite;
        !wrCntLo && !wrCntHi;
    endsequence

    sequence wordRollover;
        wordWrap && !captEn ##0 noCntWrite;
    endsequence

    sequence captureTaken;
        capture ##1 (ctrl_q[BIT_HIGH_FLAG]);
    endsequence

    wordReload_a: assert property (wordRollover |=> // RULE3
        {cntHi_q, cntLo_q} == $past({rldHi_q, rldLo_q}) && ctrl_q[BIT_HIGH_FLAG])
        else $error("word wrap did not reload");

    flagSticky_a: assert property (ctrl_q[BIT_HIGH_FLAG] && !wrCtrl // RULE11
        |=> ctrl_q[BIT_HIGH_FLAG])
        else $error("high flag cleared without software");

    lowFlagSet_a: assert property (lowWrap |=> ctrl_q[BIT_LOW_FLAG]) // RULE19
        else $error("low wrap did not set low flag");

    wordIrq_a: assert property (clkCtl_q[BIT_TIMER_IRQEN] && wordWrap && !wrClk // RULE4
        |=> timerIrq)
        else $error("word overflow raised no interrupt");

    lowIrq_a: assert property (clkCtl_q[BIT_TIMER_IRQEN] && ctrl_q[BIT_LOW_IRQEN] && lowWrap // RULE10
        && !wrCtrl && !wrClk |=> timerIrq)
        else $error("low overflow raised no interrupt");

    splitLowRuns_a: assert property (split && !run && lowTick && !wrCtrl // RULE7
        && !(lowWrap && rldLo_q == BYTE_MAX) ##0 noCntWrite // Reload of FF looks like a stall
        |=> cntLo_q != $past(cntLo_q) && cntHi_q == $past(cntHi_q))
        else $error("split run control wrong");

    captureCopy_a: assert property (capture |=> // RULE14
        {rldHi_q, rldLo_q} == $past({cntHi_q, cntLo_q}))
        else $error("capture did not copy count");

    captureFlag_a: assert property (capture && !wrCtrl |-> captureTaken) // RULE14
        else $error("capture did not set high flag");

    div12Period_a: assert property (div12Tick |=> !div12Tick [*8] ##1 !div12Tick [*3] ##1 div12Tick) // RULE2
        else $error("prescaler period is not twelve");

    // Low flag, split reload, stopped word and low-byte interrupt in word mode
    lowSticky_a: assert property (ctrl_q[BIT_LOW_FLAG] && !wrCtrl // RULE11
        |=> ctrl_q[BIT_LOW_FLAG])
        else $error("low flag cleared without software");

    splitReload_a: assert property (split && lowWrap && !wrCntLo // RULE6
        |=> cntLo_q == $past(rldLo_q))
        else $error("split low byte did not reload");

    wordHold_a: assert property (!split && !run ##0 noCntWrite // RULE20
        |=> {cntHi_q, cntLo_q} == $past({cntHi_q, cntLo_q}))
        else $error("stopped word counter moved");

    wordLowIrq_a: assert property (!split && clkCtl_q[BIT_TIMER_IRQEN] && ctrl_q[BIT_LOW_IRQEN] // RULE5
        && lowWrap && !wrCtrl && !wrClk |=> timerIrq)
        else $error("word mode low wrap raised no interrupt");

endmodule

`default_nettype wire

// [tb_top.sv]
// Self-checking bench for the reload timer: APB calls with expected values.
// Assumes rlt_pkg and rlt_timer are compiled first; extOsc runs free at 10 MHz.
`default_nettype none

module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import rlt_pkg::*;

    logic        clk     = 1'b0;
    logic        rst_n   = 1'b0;
    logic        psel    = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite  = 1'b0;
    logic [7:0]  paddr   = 8'h00;
    logic [31:0] pwdata  = 32'h0000_0000;
    logic        extOsc  = 1'b0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        timerIrq;
    logic [31:0] rd;
    logic        err;
    logic [15:0] capA;
    int          miscompares = 0;
    int          compares    = 0;

    ////////////////////////////////////////////////////////////////
    // Clocks; the oscillator pin moves on every second clk edge, 10 MHz
    always #12.5 clk = ~clk;
    always begin
        repeat (2) @(posedge clk);
        extOsc <= ~extOsc;
    end

    rlt_timer DUT (
        .clk      (clk),
        .rst_n    (rst_n),
        .psel     (psel),
        .penable  (penable),
        .pwrite   (pwrite),
        .paddr    (paddr),
        .pwdata   (pwdata),
        .prdata   (prdata),
        .pready   (pready),
        .pslverr  (pslverr),
        .extOsc   (extOsc),
        .timerIrq (timerIrq)
    );

    ////////////////////////////////////////////////////////////////
    // One APB transfer; read data and error taken at the pready edge
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        rd  = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected %s: expected %h, seen %h", name, exp, got);
        end
    endtask

    // Counts move while the bus works, so some results are a window
    task automatic chk_rng(input string name, input logic [31:0] lo, input logic [31:0] hi,
                           input logic [31:0] got);
        compares++;
        if ((^got === 1'bx) || got < lo || got > hi) begin
            miscompares++;
            $display("unexpected %s: expected %h..%h, seen %h", name, lo, hi, got);
        end
    endtask

    task automatic rdc(input string name, input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0000_0000);
        chk(name, exp, rd);
    endtask

    task automatic irq(input logic e);
        #1;
        chk("timerIrq", 32'(e), 32'(timerIrq));
    endtask

    // Poll the control word until the high flag shows, bounded
    task automatic wait_high;
        int n;
        n  = 0;
        rd = 32'h0000_0000;
        while (rd[BIT_HIGH_FLAG] !== 1'b1 && n < 100) begin
            apb(1'b0, OFF_CTRL, 32'h0000_0000);
            n++;
        end
        chk("high flag poll", 32'h0000_0001, 32'(rd[BIT_HIGH_FLAG]));
    endtask

    task automatic finish_test;
        $display("compares %0d, miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////
    // Watchdog: the tests need about 1200 cycles
    initial begin
        #(25 * 20000);
        miscompares++;
        finish_test();
    end

    initial begin
        logic [7:0] offs [6];
        offs = '{OFF_CTRL, OFF_CLKCTL, OFF_RLDLO, OFF_RLDHI, OFF_CNTLO, OFF_CNTHI};
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        foreach (offs[i]) rdc("reset value", offs[i], 32'h0000_0000);
        // Unmapped place: refused and reads zero
        apb(1'b1, 8'h18, 32'h0000_00FF);
        chk("write error", 32'h0000_0001, 32'(err));
        chk("ready", 32'h0000_0001, 32'(pready));
        rdc("unmapped read", 8'h18, 32'h0000_0000);
        chk("read error", 32'h0000_0001, 32'(err));

        // Sixteen-bit wrap at sysclk with interrupt on
        apb(1'b1, OFF_CLKCTL, 32'h0000_0005);
        apb(1'b1, OFF_RLDHI, 32'h0000_0012);
        apb(1'b1, OFF_CNTLO, 32'h0000_00F0);
        apb(1'b1, OFF_CNTHI, 32'h0000_00FF);
        apb(1'b1, OFF_CTRL, 32'h0000_0024);
        repeat (30) @(posedge clk);
        rdc("wrap flags", OFF_CTRL, 32'h0000_00E4);
        irq(1'b1);
        apb(1'b1, OFF_CTRL, 32'h0000_00C0);
        rdc("high count", OFF_CNTHI, 32'h0000_0012);
        irq(1'b1);
        apb(1'b0, OFF_CNTLO, 32'h0000_0000);
        capA = rd[15:0];
        repeat (50) @(posedge clk);
        rdc("stopped low", OFF_CNTLO, 32'(capA));
        rdc("flags kept", OFF_CTRL, 32'h0000_00C0);
        apb(1'b1, OFF_CTRL, 32'h0000_0040);
        irq(1'b0);
        apb(1'b1, OFF_CTRL, 32'h0000_0060);
        irq(1'b1);
        apb(1'b1, OFF_CTRL, 32'h0000_0000);
        irq(1'b0);

        // Split mode, high byte stopped and then run, low byte running
        apb(1'b1, OFF_CLKCTL, 32'h0000_0007);
        apb(1'b1, OFF_RLDLO, 32'h0000_0080);
        apb(1'b1, OFF_RLDHI, 32'h0000_0040);
        apb(1'b1, OFF_CNTHI, 32'h0000_00FE);
        apb(1'b1, OFF_CTRL, 32'h0000_0008);
        apb(1'b1, OFF_CNTLO, 32'h0000_00F8);
        repeat (20) @(posedge clk);
        rdc("split flags", OFF_CTRL, 32'h0000_0048);
        irq(1'b0);
        rdc("held high", OFF_CNTHI, 32'h0000_00FE);
        apb(1'b0, OFF_CNTLO, 32'h0000_0000);
        chk_rng("low reload", 32'h0000_0080, 32'h0000_009F, rd);
        apb(1'b1, OFF_CTRL, 32'h0000_000C);
        repeat (20) @(posedge clk);
        rdc("high wrap", OFF_CTRL, 32'h0000_008C);
        irq(1'b1);
        apb(1'b0, OFF_CNTHI, 32'h0000_0000);
        chk_rng("high reload", 32'h0000_0040, 32'h0000_005F, rd);
        apb(1'b1, OFF_CTRL, 32'h0000_0028);
        repeat (300) @(posedge clk);
        rdc("low only", OFF_CTRL, 32'h0000_0068);
        irq(1'b1);

        // Divided clocks: sysclk/12, then external/8
        apb(1'b1, OFF_CLKCTL, 32'h0000_0000);
        apb(1'b1, OFF_CTRL, 32'h0000_0008);
        apb(1'b1, OFF_CNTLO, 32'h0000_0000);
        repeat (118) @(posedge clk);
        apb(1'b0, OFF_CNTLO, 32'h0000_0000);
        chk_rng("div12 ticks", 32'h0000_0009, 32'h0000_000B, rd);
        apb(1'b1, OFF_CTRL, 32'h0000_0009);
        apb(1'b1, OFF_CNTLO, 32'h0000_0000);
        repeat (318) @(posedge clk);
        apb(1'b0, OFF_CNTLO, 32'h0000_0000);
        chk_rng("ext8 ticks", 32'h0000_0009, 32'h0000_000B, rd);

        // Capture at sysclk: one capture each 8 oscillator periods
        apb(1'b1, OFF_CLKCTL, 32'h0000_0001);
        apb(1'b1, OFF_CTRL, 32'h0000_0014);
        wait_high();
        apb(1'b0, OFF_RLDLO, 32'h0000_0000);
        capA[7:0] = rd[7:0];
        apb(1'b0, OFF_RLDHI, 32'h0000_0000);
        capA[15:8] = rd[7:0];
        apb(1'b1, OFF_CTRL, 32'h0000_0014);
        wait_high();
        chk("capture flag", 32'h0000_0001, 32'(rd[BIT_HIGH_FLAG]));
        apb(1'b0, OFF_RLDLO, 32'h0000_0000);
        capA[7:0] = rd[7:0] - capA[7:0];
        chk_rng("capture gap", 32'h0000_001F, 32'h0000_0021, 32'(capA[7:0]));
        // Without capture the reload byte keeps what software wrote
        apb(1'b1, OFF_CTRL, 32'h0000_0004);
        apb(1'b1, OFF_RLDLO, 32'h0000_0055);
        repeat (100) @(posedge clk);
        rdc("no capture", OFF_RLDLO, 32'h0000_0055);
        finish_test();
    end
endmodule

`default_nettype wire
